// File: nac_defines.svh
/*
 * offsets, field positions, key values and timing in ns of the nvm access block.
 * assumes it is included by bare name, after the package.
 */
`ifndef NAC_DEFINES_SVH
`define NAC_DEFINES_SVH

// ****************************************
// register indices on the sfr port
// ****************************************
`define NAC_IDX_TBL_UPPER  4'h0
`define NAC_IDX_TBL_HIGH   4'h1
`define NAC_IDX_TBL_LOW    4'h2
`define NAC_IDX_TBL_LATCH  4'h3
`define NAC_IDX_KEY        4'h4
`define NAC_IDX_CTRL       4'h5
`define NAC_IDX_DATA       4'h6
`define NAC_IDX_INDEX      4'h7
`define NAC_IDX_PRIO2      4'h8
`define NAC_IDX_FLAGS2     4'h9
`define NAC_IDX_ENAB2      4'ha

// ****************************************
// control register fields, and the done flag bit of flags2
// ****************************************
`define NAC_BIT_PROG_SEL   7
`define NAC_BIT_CFG_SEL    6
`define NAC_BIT_FREE       4
`define NAC_BIT_ABORT      3
`define NAC_BIT_PERMIT     2
`define NAC_BIT_WR         1
`define NAC_BIT_RD         0
`define NAC_BIT_DONE_FLAG  4

// ****************************************
// unlock keys, reset values, timing
// ****************************************
`define NAC_KEY_FIRST      8'h55
`define NAC_KEY_SECOND     8'haa
`define NAC_RESET_BYTE     8'h00
`define NAC_ERASED_BYTE    8'hff
`define NAC_CLK_PERIOD_NS  50
`define NAC_WRITE_TIME_NS  1000000

`endif

// File: nac_pkg.sv
/*
 * types of the nvm access block.
 * assumes nothing of its surroundings.
 */
package nac_pkg;

    // ****************************************
    // types
    // ****************************************
    typedef logic [3:0] nac_sfr_t;
    typedef logic [7:0] nac_byte_t;
    typedef enum logic [1:0] {
        NAC_KEY_IDLE,
        NAC_KEY_ONE,
        NAC_KEY_TWO
    } nac_key_e;

endpackage : nac_pkg

// File: nac_nvm_access.sv
/*
 * nvm access control: control register, unlock key port, data array,
 * self-timed write and erase, program flash requests.
 * assumes the sfr port is driven synchronously by the core, one access a cycle,
 * and sys_reset_i is a synchronous pulse for pin or watchdog resets.
 */
// Contract
// - program select chooses flash over data array
// - config select directs operations to configuration
// - writes only with permit; permit clear at power-up
// - abort flag on reset mid-cycle or bad attempt
// - space selects survive reset after abort
// - write strobe set only by software, cleared by hardware
// - write-done flag set at end, software clears
// - read strobe refused while either select set
// - read finishes in one cycle, strobe self-clears
// - data byte held until next read or write
// - row erase enable erases row, then clears
// - key port stores nothing, reads zero
// - 55h then aah unlock before strobe starts
// - byte write erases then programs, internally timed
// - control bit five reads as zero
// - data array accessed one byte at a time
// - flash write or erase stalls the core
// - strobe refused unless permit already set
// - control, index, data locked while busy
// - writes blocked during power-up timer
`include "nac_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module nac_nvm_access #(
    parameter int unsigned WRITE_CYCLES = `NAC_WRITE_TIME_NS / `NAC_CLK_PERIOD_NS
) (
    // clock and resets
    input  wire logic               mclk_i,
    input  wire logic               rstn_i,
    input  wire logic               sys_reset_i,
    input  wire logic               pwrt_active_i,
    // sfr port
    input  wire nac_pkg::nac_sfr_t  sfr_addr_i,
    input  wire logic               sfr_wr_i,
    input  wire logic               sfr_rd_i,
    input  wire nac_pkg::nac_byte_t sfr_wdata_i,
    output nac_pkg::nac_byte_t      sfr_rdata_o,
    // status
    output logic                    busy_o,
    output logic                    cpu_stall_o,
    output logic                    write_done_flag_o,
    // program flash requests
    output logic                    prog_start_o,
    output logic                    prog_erase_o,
    output logic                    prog_cfg_o,
    output logic [21:0]             prog_addr_o,
    output nac_pkg::nac_byte_t      prog_data_o
);
    import nac_pkg::*;

    // ****************************************
    // state
    // ****************************************
    nac_byte_t   mem [0:255];
    nac_byte_t   tbl_upper_reg;
    nac_byte_t   tbl_high_reg;
    nac_byte_t   tbl_low_reg;
    nac_byte_t   tbl_latch_reg;
    nac_byte_t   prio2_reg;
    nac_byte_t   flags2_reg;
    nac_byte_t   enab2_reg;
    nac_byte_t   data_reg;
    nac_byte_t   index_reg;
    nac_byte_t   rdata_reg;
    nac_byte_t   rd_mux;
    logic        prog_sel_reg;
    logic        cfg_sel_reg;
    logic        free_reg;
    logic        abort_reg;
    logic        permit_reg;
    logic        wr_reg;
    logic        rd_reg;
    logic        start_reg;
    logic [15:0] cnt_reg;
    nac_key_e    key_reg;
    logic        ctrl_wr;
    logic        key_ok;
    logic        start;
    logic        improper;
    logic        done;
    logic        half;

    // ****************************************
    // decode
    // ****************************************
    assign ctrl_wr  = sfr_wr_i && (sfr_addr_i == `NAC_IDX_CTRL) && !wr_reg;
    assign key_ok   = (key_reg == NAC_KEY_TWO) && permit_reg && !pwrt_active_i;
    assign start    = ctrl_wr && sfr_wdata_i[`NAC_BIT_WR] && key_ok && !sys_reset_i;
    assign improper = ctrl_wr && sfr_wdata_i[`NAC_BIT_WR] && !key_ok && !sys_reset_i;
    assign done     = wr_reg && (cnt_reg == 16'(WRITE_CYCLES - 1));
    assign half     = wr_reg && (cnt_reg == 16'(WRITE_CYCLES / 2));

    // ****************************************
    // unlock detector
    // ****************************************
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            key_reg <= NAC_KEY_IDLE;
        end else if (sys_reset_i) begin
            key_reg <= NAC_KEY_IDLE;
        end else if (sfr_wr_i) begin
            case (key_reg)
                NAC_KEY_IDLE: begin
                    if (sfr_addr_i == `NAC_IDX_KEY && sfr_wdata_i == `NAC_KEY_FIRST) key_reg <= NAC_KEY_ONE;
                end
                NAC_KEY_ONE: begin
                    if (sfr_addr_i == `NAC_IDX_KEY && sfr_wdata_i == `NAC_KEY_SECOND) begin
                        key_reg <= NAC_KEY_TWO;
                    end else begin
                        key_reg <= NAC_KEY_IDLE;
                    end
                end
                default: begin
                    key_reg <= NAC_KEY_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // control register
    // ****************************************
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prog_sel_reg <= 1'b0;
            cfg_sel_reg  <= 1'b0;
        end else if (ctrl_wr && !sys_reset_i) begin
            prog_sel_reg <= sfr_wdata_i[`NAC_BIT_PROG_SEL];
            cfg_sel_reg  <= sfr_wdata_i[`NAC_BIT_CFG_SEL];
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            permit_reg <= 1'b0;
            free_reg   <= 1'b0;
        end else if (sys_reset_i) begin
            permit_reg <= 1'b0;
            free_reg   <= 1'b0;
        end else if (done && free_reg) begin
            free_reg <= 1'b0;
        end else if (ctrl_wr) begin
            permit_reg <= sfr_wdata_i[`NAC_BIT_PERMIT];
            free_reg   <= sfr_wdata_i[`NAC_BIT_FREE];
        end
    end

    // abort flag: hardware set wins over a software clear
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            abort_reg <= 1'b0;
        end else if ((sys_reset_i && wr_reg) || improper) begin
            abort_reg <= 1'b1;
        end else if (done) begin
            abort_reg <= 1'b0;
        end else if (ctrl_wr && !sys_reset_i) begin
            abort_reg <= sfr_wdata_i[`NAC_BIT_ABORT];
        end
    end

    // ****************************************
    // write strobe and cycle timer
    // ****************************************
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_reg <= 1'b0;
        end else if (sys_reset_i || done) begin
            wr_reg <= 1'b0;
        end else if (start) begin
            wr_reg <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_reg <= 16'h0000;
        end else if (!wr_reg || sys_reset_i || done) begin
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= start && (sfr_wdata_i[`NAC_BIT_PROG_SEL] || sfr_wdata_i[`NAC_BIT_CFG_SEL]);
        end
    end

    // ****************************************
    // read strobe, data byte, index, array
    // ****************************************
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_reg <= 1'b0;
        end else if (sys_reset_i || rd_reg) begin
            rd_reg <= 1'b0;
        end else if (ctrl_wr && sfr_wdata_i[`NAC_BIT_RD]) begin
            rd_reg <= !sfr_wdata_i[`NAC_BIT_PROG_SEL] && !sfr_wdata_i[`NAC_BIT_CFG_SEL];
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            data_reg <= `NAC_RESET_BYTE;
        end else if (rd_reg) begin
            data_reg <= mem[index_reg];
        end else if (sfr_wr_i && sfr_addr_i == `NAC_IDX_DATA && !wr_reg) begin
            data_reg <= sfr_wdata_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            index_reg <= `NAC_RESET_BYTE;
        end else if (sfr_wr_i && sfr_addr_i == `NAC_IDX_INDEX && !wr_reg) begin
            index_reg <= sfr_wdata_i;
        end
    end

    // data target only: erase at mid-cycle, program at the end
    always_ff @(posedge mclk_i) begin
        if (!prog_sel_reg && !cfg_sel_reg && !sys_reset_i) begin
            if (half) begin
                mem[index_reg] <= `NAC_ERASED_BYTE;
            end else if (done) begin
                mem[index_reg] <= data_reg;
            end
        end
    end

    // ****************************************
    // table pointer, latch, peripheral regs
    // ****************************************
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tbl_upper_reg <= `NAC_RESET_BYTE;
            tbl_high_reg  <= `NAC_RESET_BYTE;
            tbl_low_reg   <= `NAC_RESET_BYTE;
            tbl_latch_reg <= `NAC_RESET_BYTE;
            prio2_reg     <= `NAC_RESET_BYTE;
            enab2_reg     <= `NAC_RESET_BYTE;
        end else if (sfr_wr_i) begin
            case (sfr_addr_i)
                `NAC_IDX_TBL_UPPER: tbl_upper_reg <= sfr_wdata_i;
                `NAC_IDX_TBL_HIGH:  tbl_high_reg  <= sfr_wdata_i;
                `NAC_IDX_TBL_LOW:   tbl_low_reg   <= sfr_wdata_i;
                `NAC_IDX_TBL_LATCH: tbl_latch_reg <= sfr_wdata_i;
                `NAC_IDX_PRIO2:     prio2_reg     <= sfr_wdata_i;
                `NAC_IDX_ENAB2:     enab2_reg     <= sfr_wdata_i;
                default: begin
                end
            endcase
        end
    end

    // done flag: completion wins over a software clear in the same cycle
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flags2_reg <= `NAC_RESET_BYTE;
        end else begin
            if (sfr_wr_i && sfr_addr_i == `NAC_IDX_FLAGS2) begin
                flags2_reg <= sfr_wdata_i;
            end
            if (done) begin
                flags2_reg[`NAC_BIT_DONE_FLAG] <= 1'b1;
            end
        end
    end

    // ****************************************
    // read back
    // ****************************************
    always_comb begin
        case (sfr_addr_i)
            `NAC_IDX_TBL_UPPER: rd_mux = tbl_upper_reg;
            `NAC_IDX_TBL_HIGH:  rd_mux = tbl_high_reg;
            `NAC_IDX_TBL_LOW:   rd_mux = tbl_low_reg;
            `NAC_IDX_TBL_LATCH: rd_mux = tbl_latch_reg;
            `NAC_IDX_CTRL:      rd_mux = {prog_sel_reg, cfg_sel_reg, 1'b0, free_reg,
                                          abort_reg, permit_reg, wr_reg, rd_reg};
            `NAC_IDX_DATA:      rd_mux = data_reg;
            `NAC_IDX_INDEX:     rd_mux = index_reg;
            `NAC_IDX_PRIO2:     rd_mux = prio2_reg;
            `NAC_IDX_FLAGS2:    rd_mux = flags2_reg;
            `NAC_IDX_ENAB2:     rd_mux = enab2_reg;
            default:            rd_mux = `NAC_RESET_BYTE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_reg <= `NAC_RESET_BYTE;
        end else if (sfr_rd_i) begin
            rdata_reg <= rd_mux;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign sfr_rdata_o       = rdata_reg;
    assign busy_o            = wr_reg;
    assign cpu_stall_o       = wr_reg && (prog_sel_reg || cfg_sel_reg);
    assign write_done_flag_o = flags2_reg[`NAC_BIT_DONE_FLAG];
    assign prog_start_o      = start_reg;
    assign prog_erase_o      = wr_reg && free_reg;
    assign prog_cfg_o        = wr_reg && cfg_sel_reg;
    assign prog_addr_o       = {tbl_upper_reg[5:0], tbl_high_reg, tbl_low_reg};
    assign prog_data_o       = tbl_latch_reg;

    // ****************************************
    // checks
    // ****************************************
    unlock_start_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $rose(wr_reg) |-> $past(key_reg) == NAC_KEY_TWO)
        else $error("write started without unlock");
    permit_before_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $rose(wr_reg) |-> $past(permit_reg) && !$past(pwrt_active_i))
        else $error("write started without prior permit");
    read_refused_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        $rose(rd_reg) |-> !prog_sel_reg && !cfg_sel_reg)
        else $error("read started with a select set");
    read_one_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        rd_reg |=> !rd_reg && data_reg == mem[$past(index_reg)])
        else $error("read not done in one cycle");
    done_flag_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        done |=> write_done_flag_o && !wr_reg)
        else $error("done flag not set at end of write");
    abort_reset_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        sys_reset_i && wr_reg |=> abort_reg && !wr_reg)
        else $error("abort flag missed on reset");
    select_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        sys_reset_i |=> prog_sel_reg == $past(prog_sel_reg) && cfg_sel_reg == $past(cfg_sel_reg))
        else $error("selects changed by reset");
    busy_lock_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        wr_reg && !done |=> $stable(index_reg) && $stable(prog_sel_reg))
        else $error("registers changed while busy");
    busy_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i || sys_reset_i)
        $rose(wr_reg) && !sys_reset_i |-> wr_reg [*8])
        else $error("write cycle too short");
    key_zero_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        sfr_rd_i && sfr_addr_i == `NAC_IDX_KEY |=> sfr_rdata_o == 8'h00)
        else $error("key port read not zero");
    stall_flash_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        wr_reg && prog_sel_reg |-> cpu_stall_o)
        else $error("no stall during flash write");
    erase_half_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        half && !prog_sel_reg && !cfg_sel_reg && !sys_reset_i |=> mem[index_reg] == `NAC_ERASED_BYTE)
        else $error("data byte not erased mid-cycle");

endmodule : nac_nvm_access

`default_nettype wire

// File: tb.sv
/*
 * self-checking testbench of the nvm access block: sfr read and write tasks,
 * unlock sequences, data array write and read, flash erase, refusals, resets.
 * assumes nac_pkg and nac_defines.svh are compiled before it.
 */
`include "nac_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module tb;
    import nac_pkg::*;

    // ****************************************
    // signals
    // ****************************************
    localparam int    WC = 16;
    logic             mclk_i        = 1'b0;
    logic             rstn_i        = 1'b0;
    logic             sys_reset_i   = 1'b0;
    logic             pwrt_active_i = 1'b0;
    nac_sfr_t         sfr_addr_i    = 4'h0;
    logic             sfr_wr_i      = 1'b0;
    logic             sfr_rd_i      = 1'b0;
    nac_byte_t        sfr_wdata_i   = 8'h00;
    nac_byte_t        sfr_rdata_o;
    logic             busy_o;
    logic             cpu_stall_o;
    logic             write_done_flag_o;
    logic             prog_start_o;
    logic             prog_erase_o;
    logic             prog_cfg_o;
    logic [21:0]      prog_addr_o;
    nac_byte_t        prog_data_o;
    int               miscompares   = 0;
    int               checks_done   = 0;
    int               starts        = 0;
    nac_byte_t        r;

    always #25 mclk_i = ~mclk_i;

    always @(posedge mclk_i) begin
        if (prog_start_o === 1'b1) begin
            starts <= starts + 1;
        end
    end

    nac_nvm_access #(.WRITE_CYCLES(WC)) DUT (
        .mclk_i            (mclk_i),
        .rstn_i            (rstn_i),
        .sys_reset_i       (sys_reset_i),
        .pwrt_active_i     (pwrt_active_i),
        .sfr_addr_i        (sfr_addr_i),
        .sfr_wr_i          (sfr_wr_i),
        .sfr_rd_i          (sfr_rd_i),
        .sfr_wdata_i       (sfr_wdata_i),
        .sfr_rdata_o       (sfr_rdata_o),
        .busy_o            (busy_o),
        .cpu_stall_o       (cpu_stall_o),
        .write_done_flag_o (write_done_flag_o),
        .prog_start_o      (prog_start_o),
        .prog_erase_o      (prog_erase_o),
        .prog_cfg_o        (prog_cfg_o),
        .prog_addr_o       (prog_addr_o),
        .prog_data_o       (prog_data_o)
    );

    // ****************************************
    // access tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input nac_sfr_t a, input nac_byte_t d);
        @(negedge mclk_i);
        sfr_rd_i    = 1'b0;
        sfr_wr_i    = 1'b1;
        sfr_addr_i  = a;
        sfr_wdata_i = d;
        @(posedge mclk_i);
    endtask : wr

    task automatic idle(input int n);
        @(negedge mclk_i);
        sfr_wr_i = 1'b0;
        sfr_rd_i = 1'b0;
        repeat (n - 1) @(negedge mclk_i);
    endtask : idle

    task automatic rd(input nac_sfr_t a, output nac_byte_t d);
        @(negedge mclk_i);
        sfr_wr_i   = 1'b0;
        sfr_rd_i   = 1'b1;
        sfr_addr_i = a;
        @(negedge mclk_i);
        sfr_rd_i = 1'b0;
        d        = sfr_rdata_o;
    endtask : rd

    task automatic unlock_start(input nac_byte_t c);
        wr(`NAC_IDX_CTRL, c);
        wr(`NAC_IDX_KEY, `NAC_KEY_FIRST);
        wr(`NAC_IDX_KEY, `NAC_KEY_SECOND);
        wr(`NAC_IDX_CTRL, c | 8'h02);
        idle(2);
    endtask : unlock_start

    task automatic wait_idle;
        int k;
        k = 0;
        while (busy_o !== 1'b0 && k < 4 * WC) begin
            @(negedge mclk_i);
            k++;
        end
        chk("busy end", 32'h0, {31'h0, busy_o});
    endtask : wait_idle

    task automatic tend(input string n);
        $display("test %s done", n);
    endtask : tend

    task automatic test_done;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    // ****************************************
    // watchdog
    // ****************************************
    initial begin
        repeat (5000) @(posedge mclk_i);
        miscompares++;
        test_done();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (10) @(negedge mclk_i);
        rstn_i = 1'b1;
        rd(`NAC_IDX_CTRL, r);   chk("ctrl reset", 8'h00, r);
        rd(`NAC_IDX_KEY, r);    chk("key read", 8'h00, r);
        rd(4'hb, r);            chk("unmapped", 8'h00, r);
        wr(`NAC_IDX_CTRL, 8'h20);
        rd(`NAC_IDX_CTRL, r);   chk("bit five", 8'h00, r);
        tend("reset");

        wr(`NAC_IDX_KEY, `NAC_KEY_FIRST);
        wr(`NAC_IDX_KEY, `NAC_KEY_SECOND);
        wr(`NAC_IDX_CTRL, 8'h06);
        idle(2);
        chk("no permit busy", 32'h0, {31'h0, busy_o});
        rd(`NAC_IDX_CTRL, r);   chk("abort set", 8'h0c, r);
        tend("permit");

        wr(`NAC_IDX_INDEX, 8'h10);
        wr(`NAC_IDX_DATA, 8'ha5);
        unlock_start(8'h04);
        chk("busy", 32'h1, {31'h0, busy_o});
        chk("no stall", 32'h0, {31'h0, cpu_stall_o});
        wr(`NAC_IDX_DATA, 8'h33);
        wr(`NAC_IDX_INDEX, 8'h11);
        wr(`NAC_IDX_CTRL, 8'h00);
        idle(1);
        wait_idle();
        chk("done flag", 32'h1, {31'h0, write_done_flag_o});
        rd(`NAC_IDX_CTRL, r);   chk("ctrl after", 8'h04, r);
        rd(`NAC_IDX_FLAGS2, r); chk("flags2", 8'h10, r);
        rd(`NAC_IDX_INDEX, r);  chk("index lock", 8'h10, r);
        wr(`NAC_IDX_DATA, 8'h00);
        wr(`NAC_IDX_CTRL, 8'h05);
        idle(2);
        rd(`NAC_IDX_CTRL, r);   chk("rd clear", 8'h04, r);
        rd(`NAC_IDX_DATA, r);   chk("read back", 8'ha5, r);
        wr(`NAC_IDX_FLAGS2, 8'h00);
        idle(1);
        chk("flag clear", 32'h0, {31'h0, write_done_flag_o});
        tend("data write");

        wr(`NAC_IDX_DATA, 8'h11);
        wr(`NAC_IDX_CTRL, 8'h81);
        idle(2);
        rd(`NAC_IDX_DATA, r);   chk("rd refused p", 8'h11, r);
        rd(`NAC_IDX_CTRL, r);   chk("ctrl p", 8'h80, r);
        wr(`NAC_IDX_CTRL, 8'h41);
        idle(2);
        rd(`NAC_IDX_DATA, r);   chk("rd refused c", 8'h11, r);
        rd(`NAC_IDX_CTRL, r);   chk("ctrl c", 8'h40, r);
        tend("read refusal");

        wr(`NAC_IDX_CTRL, 8'h04);
        wr(`NAC_IDX_KEY, `NAC_KEY_FIRST);
        wr(`NAC_IDX_INDEX, 8'h12);
        wr(`NAC_IDX_KEY, `NAC_KEY_SECOND);
        wr(`NAC_IDX_CTRL, 8'h06);
        idle(2);
        chk("broken busy", 32'h0, {31'h0, busy_o});
        rd(`NAC_IDX_CTRL, r);   chk("broken", 8'h08, r & 8'h0a);
        @(negedge mclk_i);
        pwrt_active_i = 1'b1;
        unlock_start(8'h04);
        chk("pwrt busy", 32'h0, {31'h0, busy_o});
        pwrt_active_i = 1'b0;
        tend("refusals");

        wr(`NAC_IDX_TBL_UPPER, 8'h01);
        wr(`NAC_IDX_TBL_HIGH, 8'h23);
        wr(`NAC_IDX_TBL_LOW, 8'h45);
        wr(`NAC_IDX_TBL_LATCH, 8'h5a);
        unlock_start(8'h94);
        chk("stall", 32'h1, {31'h0, cpu_stall_o});
        chk("erase", 32'h1, {31'h0, prog_erase_o});
        chk("addr", 32'h012345, {10'h0, prog_addr_o});
        chk("pdata", 8'h5a, prog_data_o);
        wait_idle();
        chk("start pulses", 32'd1, starts);
        rd(`NAC_IDX_CTRL, r);   chk("free clear", 8'h84, r);
        tend("flash erase");

        unlock_start(8'h44);
        chk("cfg", 32'h1, {31'h0, prog_cfg_o});
        @(negedge mclk_i);
        sys_reset_i = 1'b1;
        @(negedge mclk_i);
        sys_reset_i = 1'b0;
        idle(1);
        chk("reset busy", 32'h0, {31'h0, busy_o});
        rd(`NAC_IDX_CTRL, r);   chk("trace", 8'h48, r);
        chk("cfg pulses", 32'd2, starts);
        tend("abort");
        test_done();
    end

endmodule : tb

`default_nettype wire
